// ---- verilog/trim_alu_pkg.sv ----
// Package: constants and types of the temperature compensation trim ALU
// Function
// - Room reference is 12 bits in words 0 to 2; its top bit must be zero.
// - Reference low 11 bits are an unsigned fraction zero to one, 11-bit resolution.
// - Gain zero-order term: words 12 to 14, low 10 bits used, top two zero.
// - Gain first-order term: signed 12 bits, words 8 to 10, range minus two to two.
// - Gain second-order term: signed 12 bits, words 4 to 6, range minus two to two.
// - Gain polynomial is evaluated at 12-bit precision, truncated to a 10-bit code.
// - Gain fraction outside zero to one raises the fault.
// - Offset fraction is zero term plus first times delta plus second times delta squared.
// - Offset zero-order term: words 28 to 30, low 10 bits used, top two zero.
// - Offset first-order term: signed 12 bits, words 24 to 26, minus two to two.
// - Offset second-order term: signed 12 bits, words 20 to 22, minus two to two.
// - Offset polynomial is evaluated at 12-bit precision, truncated to a 10-bit code.
// - Offset fraction outside zero to one raises the fault.
// - Coarse offset is a 7-bit code from words 11 and 15, passed on unchanged.
// - Output is limited by a 3-bit low clamp code and a 3-bit high clamp code.
// - Filter node above high threshold selects high; below low threshold selects low.
// - Low clamp code, zero to seven, sits in word 19.
// - High clamp code, zero to seven, spreads over words 19 and 23.
// - Gain fraction is zero term plus first times delta plus second times delta squared.
// - Each memory word has four data bits and a parity bit; ones count is odd.
// - Input swap bit in word 7 exchanges the two differential sensor inputs.
package trim_alu_pkg;

    // Calibration memory geometry
    localparam int MEM_WORDS = 64;
    localparam int MEM_AW    = 6;
    localparam int WORD_W    = 5;
    localparam int NIB_W     = 4;

    // Word addresses; multi-word values are stored low nibble first
    localparam logic [MEM_AW-1:0] ADDR_ROOM_TEMP_REF  = 6'h00;
    localparam logic [MEM_AW-1:0] ADDR_GAIN_SECOND    = 6'h04;
    localparam logic [MEM_AW-1:0] ADDR_SWAP_OPTION    = 6'h07;
    localparam logic [MEM_AW-1:0] ADDR_GAIN_FIRST     = 6'h08;
    localparam logic [MEM_AW-1:0] ADDR_COARSE_LOW     = 6'h0B;
    localparam logic [MEM_AW-1:0] ADDR_GAIN_ZERO      = 6'h0C;
    localparam logic [MEM_AW-1:0] ADDR_COARSE_HIGH    = 6'h0F;
    localparam logic [MEM_AW-1:0] ADDR_CLAMP_SHARED   = 6'h13;
    localparam logic [MEM_AW-1:0] ADDR_OFFSET_SECOND  = 6'h14;
    localparam logic [MEM_AW-1:0] ADDR_CLAMP_HIGH_TOP = 6'h17;
    localparam logic [MEM_AW-1:0] ADDR_OFFSET_FIRST   = 6'h18;
    localparam logic [MEM_AW-1:0] ADDR_OFFSET_ZERO    = 6'h1C;

    // Field positions
    localparam int SWAP_BIT        = 0;
    localparam int LOW_CLAMP_LSB   = 0;
    localparam int HIGH_CLAMP_BIT0 = 3;
    localparam int PARITY_BIT      = 4;

    // Widths
    localparam int TEMP_W   = 10;
    localparam int FRAC_W   = 11;
    localparam int COEF_W   = 12;
    localparam int PREC_W   = 12;
    localparam int DAC_W    = 10;
    localparam int COARSE_W = 7;
    localparam int CLAMP_W  = 3;

    // Reset values: an erased word is zero data with odd parity
    localparam logic [WORD_W-1:0] MEM_RESET_WORD = 5'h10;
    localparam logic [DAC_W-1:0]  DAC_RESET_CODE = 10'h000;

    typedef struct packed {
        logic              en;
        logic [MEM_AW-1:0] addr;
        logic [WORD_W-1:0] data;
    } mem_wr_t;

    typedef struct packed {
        logic              valid;
        logic [TEMP_W-1:0] code;
    } temp_in_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_CALC  = 3'h2,
        ST_LATCH = 3'h4
    } alu_state_t;

    typedef enum logic [1:0] {
        CLAMP_PASS = 2'h0,
        CLAMP_LOW  = 2'h1,
        CLAMP_HIGH = 2'h2
    } clamp_sel_t;

endpackage

// ---- verilog/trim_poly_eval.sv ----
// Second-order temperature polynomial with range check and DAC truncation
`timescale 1ns/1ps
module trim_poly_eval #(
    parameter int CW = trim_alu_pkg::COEF_W,
    parameter int DW = trim_alu_pkg::COEF_W,
    parameter int PW = trim_alu_pkg::PREC_W,
    parameter int OW = trim_alu_pkg::DAC_W
) (
    // Coefficients: zero term unsigned, others signed with CW-2 fraction bits
    input  wire logic [CW-1:0] coefZero,
    input  wire logic [CW-1:0] coefFirst,
    input  wire logic [CW-1:0] coefSecond,
    // Temperature delta, signed, DW-1 fraction bits
    input  wire logic [DW-1:0] tempDelta,
    // Result
    output logic [OW-1:0]      dacCode,
    output logic               rangeErr
);
    import trim_alu_pkg::*;

    localparam int SH    = (CW - 2) + (DW - 1) - PW;
    localparam int ACC_W = PW + 6;

    logic signed [DW-1:0]    d;
    logic signed [2*DW-1:0]  sq;
    logic signed [DW:0]      sqScaled;
    logic signed [CW+DW-1:0] t1;
    logic signed [CW+DW:0]   t2;
    logic signed [ACC_W-1:0] acc;

    always_comb begin
        d        = signed'(tempDelta);
        sq       = d * d;
        // Square back to DW-1 fraction bits; never negative
        sqScaled = sq[2*DW-1:DW-1];
        t1       = signed'(coefFirst) * d;
        t2       = signed'(coefSecond) * sqScaled;
        // Only the low OW bits of the zero term take part
        acc      = ACC_W'(t1 >>> SH) + ACC_W'(t2 >>> SH)
                 + signed'(ACC_W'({coefZero[OW-1:0], {(PW-OW){1'b0}}}));
        // Fraction must lie in zero up to (not including) one
        rangeErr = acc[ACC_W-1] | (|acc[ACC_W-2:PW]);
        if (!rangeErr) begin
            // Drop the two guard bits for the DAC
            dacCode = acc[PW-1 -: OW];
        end else if (acc[ACC_W-1]) begin
            dacCode = {OW{1'b0}};
        end else begin
            dacCode = {OW{1'b1}};
        end
    end

endmodule // trim_poly_eval

// ---- verilog/temp_comp_fine_trim_alu.sv ----
// Top: calibration words, fine trim ALU, coarse and clamp codes, clamp selection
`timescale 1ns/1ps
module temp_comp_fine_trim_alu (
    // Clock and reset
    input  wire logic                                   core_clk,
    input  wire logic                                   srst,
    // Calibration memory access
    input  wire trim_alu_pkg::mem_wr_t                  memWr,
    input  wire logic [trim_alu_pkg::MEM_AW-1:0]        memRdAddr,
    output logic [trim_alu_pkg::WORD_W-1:0]             memRdData,
    // Temperature converter
    input  wire trim_alu_pkg::temp_in_t                 tempIn,
    // Filter node comparators, asynchronous
    input  wire logic                                   filterAboveHigh,
    input  wire logic                                   filterBelowLow,
    // Trim codes
    output logic [trim_alu_pkg::DAC_W-1:0]              gainDacCode,
    output logic [trim_alu_pkg::DAC_W-1:0]              offsetDacCode,
    output logic [trim_alu_pkg::COARSE_W-1:0]           coarseOffsetCode,
    output logic [trim_alu_pkg::CLAMP_W-1:0]            lowClampCode,
    output logic [trim_alu_pkg::CLAMP_W-1:0]            highClampCode,
    output logic                                        inputSwapOption,
    output trim_alu_pkg::clamp_sel_t                    clampSel,
    // Status
    output logic                                        resultValid,
    output logic                                        faultOut,
    output logic                                        gainRangeErr,
    output logic                                        offsetRangeErr,
    output logic                                        parityFault,
    output logic                                        formatFault
);
    import trim_alu_pkg::*;

    function automatic logic oddParity(input logic [WORD_W-1:0] w);
        oddParity = ^w;
    endfunction

    // Calibration memory
    logic [WORD_W-1:0] mem_q [MEM_WORDS];
    logic [WORD_W-1:0] mem_d [MEM_WORDS];
    logic [WORD_W-1:0] memRdData_q;
    logic [WORD_W-1:0] memRdData_d;
    logic              parityFault_q;
    logic              parityFault_d;

    function automatic logic [COEF_W-1:0] readCoef(input logic [MEM_AW-1:0] base);
        readCoef = {mem_q[base + 6'h02][NIB_W-1:0],
                    mem_q[base + 6'h01][NIB_W-1:0],
                    mem_q[base][NIB_W-1:0]};
    endfunction

    always_comb begin
        for (int i = 0; i < MEM_WORDS; i++) begin
            mem_d[i] = mem_q[i];
        end
        if (memWr.en) begin
            mem_d[memWr.addr] = memWr.data;
        end
        memRdData_d   = mem_q[memRdAddr];
        parityFault_d = 1'b0;
        for (int i = 0; i < MEM_WORDS; i++) begin
            if (!oddParity(mem_q[i])) begin
                parityFault_d = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            for (int i = 0; i < MEM_WORDS; i++) begin
                mem_q[i] <= MEM_RESET_WORD;
            end
            memRdData_q   <= MEM_RESET_WORD;
            parityFault_q <= 1'b0;
        end else begin
            mem_q         <= mem_d;
            memRdData_q   <= memRdData_d;
            parityFault_q <= parityFault_d;
        end
    end

    // Decoded calibration values
    logic [COEF_W-1:0] roomTempReference;
    logic [COEF_W-1:0] gainCoefZeroOrder;
    logic [COEF_W-1:0] gainCoefFirstOrder;
    logic [COEF_W-1:0] gainCoefSecondOrder;
    logic [COEF_W-1:0] offsetCoefZeroOrder;
    logic [COEF_W-1:0] offsetCoefFirstOrder;
    logic [COEF_W-1:0] offsetCoefSecondOrder;

    always_comb begin
        roomTempReference     = readCoef(ADDR_ROOM_TEMP_REF);
        gainCoefZeroOrder     = readCoef(ADDR_GAIN_ZERO);
        gainCoefFirstOrder    = readCoef(ADDR_GAIN_FIRST);
        gainCoefSecondOrder   = readCoef(ADDR_GAIN_SECOND);
        offsetCoefZeroOrder   = readCoef(ADDR_OFFSET_ZERO);
        offsetCoefFirstOrder  = readCoef(ADDR_OFFSET_FIRST);
        offsetCoefSecondOrder = readCoef(ADDR_OFFSET_SECOND);
    end

    // Sequencer and ALU
    alu_state_t        state_q;
    alu_state_t        state_d;
    logic [TEMP_W-1:0] tempCode_q;
    logic [TEMP_W-1:0] tempCode_d;
    logic [COEF_W-1:0] delta_q;
    logic [COEF_W-1:0] delta_d;
    logic [DAC_W-1:0]  gainCode;
    logic [DAC_W-1:0]  offsetCode;
    logic              gainErr;
    logic              offsetErr;
    logic [DAC_W-1:0]  gainDac_q;
    logic [DAC_W-1:0]  gainDac_d;
    logic [DAC_W-1:0]  offsetDac_q;
    logic [DAC_W-1:0]  offsetDac_d;
    logic              gainRange_q;
    logic              gainRange_d;
    logic              offsetRange_q;
    logic              offsetRange_d;
    logic              fault_q;
    logic              fault_d;
    logic              valid_q;
    logic              valid_d;
    logic              format_q;
    logic              format_d;

    trim_poly_eval #(
        .CW (COEF_W),
        .DW (COEF_W),
        .PW (PREC_W),
        .OW (DAC_W)
    ) u_gain_poly (
        .coefZero   (gainCoefZeroOrder),
        .coefFirst  (gainCoefFirstOrder),
        .coefSecond (gainCoefSecondOrder),
        .tempDelta  (delta_q),
        .dacCode    (gainCode),
        .rangeErr   (gainErr)
    );

    trim_poly_eval #(
        .CW (COEF_W),
        .DW (COEF_W),
        .PW (PREC_W),
        .OW (DAC_W)
    ) u_offset_poly (
        .coefZero   (offsetCoefZeroOrder),
        .coefFirst  (offsetCoefFirstOrder),
        .coefSecond (offsetCoefSecondOrder),
        .tempDelta  (delta_q),
        .dacCode    (offsetCode),
        .rangeErr   (offsetErr)
    );

    always_comb begin
        state_d       = state_q;
        tempCode_d    = tempCode_q;
        delta_d       = delta_q;
        gainDac_d     = gainDac_q;
        offsetDac_d   = offsetDac_q;
        gainRange_d   = gainRange_q;
        offsetRange_d = offsetRange_q;
        fault_d       = fault_q;
        valid_d       = 1'b0;
        // Top bits that must be zero are ignored by the ALU but reported
        format_d      = roomTempReference[COEF_W-1]
                      | (|gainCoefZeroOrder[COEF_W-1:DAC_W])
                      | (|offsetCoefZeroOrder[COEF_W-1:DAC_W]);
        case (state_q)
            ST_IDLE: begin
                // Samples arriving while busy are dropped, not queued
                if (tempIn.valid) begin
                    tempCode_d = tempIn.code;
                    state_d    = ST_CALC;
                end
            end
            ST_CALC: begin
                // Code scaled to the reference's 11 fraction bits
                delta_d = {1'b0, tempCode_q, 1'b0}
                        - {1'b0, roomTempReference[FRAC_W-1:0]};
                state_d = ST_LATCH;
            end
            ST_LATCH: begin
                gainDac_d     = gainCode;
                offsetDac_d   = offsetCode;
                gainRange_d   = gainErr;
                offsetRange_d = offsetErr;
                fault_d       = gainErr | offsetErr;
                valid_d       = 1'b1;
                state_d       = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q       <= ST_IDLE;
            tempCode_q    <= {TEMP_W{1'b0}};
            delta_q       <= {COEF_W{1'b0}};
            gainDac_q     <= DAC_RESET_CODE;
            offsetDac_q   <= DAC_RESET_CODE;
            gainRange_q   <= 1'b0;
            offsetRange_q <= 1'b0;
            fault_q       <= 1'b0;
            valid_q       <= 1'b0;
            format_q      <= 1'b0;
        end else begin
            state_q       <= state_d;
            tempCode_q    <= tempCode_d;
            delta_q       <= delta_d;
            gainDac_q     <= gainDac_d;
            offsetDac_q   <= offsetDac_d;
            gainRange_q   <= gainRange_d;
            offsetRange_q <= offsetRange_d;
            fault_q       <= fault_d;
            valid_q       <= valid_d;
            format_q      <= format_d;
        end
    end

    // Static codes, clamp selection and comparator synchronisers
    logic [COARSE_W-1:0] coarse_q;
    logic [COARSE_W-1:0] coarse_d;
    logic [CLAMP_W-1:0]  lowClamp_q;
    logic [CLAMP_W-1:0]  lowClamp_d;
    logic [CLAMP_W-1:0]  highClamp_q;
    logic [CLAMP_W-1:0]  highClamp_d;
    logic                swap_q;
    logic                swap_d;
    logic [2:0]          aboveSync_q;
    logic [2:0]          aboveSync_d;
    logic [2:0]          belowSync_q;
    logic [2:0]          belowSync_d;
    logic                aboveFilt_q;
    logic                aboveFilt_d;
    logic                belowFilt_q;
    logic                belowFilt_d;
    clamp_sel_t          clampSel_q;
    clamp_sel_t          clampSel_d;

    always_comb begin
        coarse_d    = {mem_q[ADDR_COARSE_HIGH][COARSE_W-NIB_W-1:0],
                       mem_q[ADDR_COARSE_LOW][NIB_W-1:0]};
        lowClamp_d  = mem_q[ADDR_CLAMP_SHARED][LOW_CLAMP_LSB +: CLAMP_W];
        highClamp_d = {mem_q[ADDR_CLAMP_HIGH_TOP][CLAMP_W-2:0],
                       mem_q[ADDR_CLAMP_SHARED][HIGH_CLAMP_BIT0]};
        swap_d      = mem_q[ADDR_SWAP_OPTION][SWAP_BIT];
        aboveSync_d = {aboveSync_q[1:0], filterAboveHigh};
        belowSync_d = {belowSync_q[1:0], filterBelowLow};
        // A change counts only once the second and third stages agree
        aboveFilt_d = (aboveSync_q[1] == aboveSync_q[2]) ? aboveSync_q[2] : aboveFilt_q;
        belowFilt_d = (belowSync_q[1] == belowSync_q[2]) ? belowSync_q[2] : belowFilt_q;
        // High wins if both comparators trip, as with a shorted filter node
        if (aboveFilt_q) begin
            clampSel_d = CLAMP_HIGH;
        end else if (belowFilt_q) begin
            clampSel_d = CLAMP_LOW;
        end else begin
            clampSel_d = CLAMP_PASS;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            coarse_q    <= {COARSE_W{1'b0}};
            lowClamp_q  <= {CLAMP_W{1'b0}};
            highClamp_q <= {CLAMP_W{1'b0}};
            swap_q      <= 1'b0;
            aboveSync_q <= 3'h0;
            belowSync_q <= 3'h0;
            aboveFilt_q <= 1'b0;
            belowFilt_q <= 1'b0;
            clampSel_q  <= CLAMP_PASS;
        end else begin
            coarse_q    <= coarse_d;
            lowClamp_q  <= lowClamp_d;
            highClamp_q <= highClamp_d;
            swap_q      <= swap_d;
            aboveSync_q <= aboveSync_d;
            belowSync_q <= belowSync_d;
            aboveFilt_q <= aboveFilt_d;
            belowFilt_q <= belowFilt_d;
            clampSel_q  <= clampSel_d;
        end
    end

    assign memRdData        = memRdData_q;
    assign gainDacCode      = gainDac_q;
    assign offsetDacCode    = offsetDac_q;
    assign coarseOffsetCode = coarse_q;
    assign lowClampCode     = lowClamp_q;
    assign highClampCode    = highClamp_q;
    assign inputSwapOption  = swap_q;
    assign clampSel         = clampSel_q;
    assign resultValid      = valid_q;
    assign faultOut         = fault_q;
    assign gainRangeErr     = gainRange_q;
    assign offsetRangeErr   = offsetRange_q;
    assign parityFault      = parityFault_q;
    assign formatFault      = format_q;

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    a_valid_delay: assert property (state_q == ST_IDLE && tempIn.valid |-> ##3 valid_q)
        else $error("result not valid three cycles after sample");
    a_gain_zero_delta: assert property (
        (valid_q && $past(delta_q) == 12'h000 && !gainRange_q)
        |-> gainDac_q == $past(gainCoefZeroOrder[DAC_W-1:0]))
        else $error("gain code differs from zero term at zero delta");
    a_offset_zero_delta: assert property (
        (valid_q && $past(delta_q) == 12'h000 && !offsetRange_q)
        |-> offsetDac_q == $past(offsetCoefZeroOrder[DAC_W-1:0]))
        else $error("offset code differs from zero term at zero delta");
    a_gain_fault: assert property ((valid_q && gainRange_q) |-> fault_q)
        else $error("gain range error without fault");
    a_offset_fault: assert property ((valid_q && offsetRange_q) |-> fault_q)
        else $error("offset range error without fault");
    a_fault_holds: assert property (!valid_q |-> $stable(fault_q))
        else $error("fault changed outside a result update");
    a_clamp_high: assert property ((&aboveSync_q[2:1])[*2] |=> clampSel_q == CLAMP_HIGH)
        else $error("high clamp not selected");
    a_clamp_low: assert property (
        (belowSync_q[2] && belowSync_q[1] && !aboveFilt_q && !aboveFilt_d)[*2]
        |=> clampSel_q == CLAMP_LOW)
        else $error("low clamp not selected");
    a_parity_bad: assert property (memWr.en && !(^memWr.data) |-> ##2 parityFault_q)
        else $error("even parity word not flagged");
    a_coarse_code: assert property (memWr.en && memWr.addr == ADDR_COARSE_LOW
        |-> ##2 coarse_q[NIB_W-1:0] == $past(memWr.data[NIB_W-1:0], 2))
        else $error("coarse offset code not passed through");
    a_ref_format: assert property (roomTempReference[COEF_W-1] |=> format_q)
        else $error("reference top bit set without format fault");
    a_swap_bit: assert property (memWr.en && memWr.addr == ADDR_SWAP_OPTION
        |-> ##2 swap_q == $past(memWr.data[SWAP_BIT], 2))
        else $error("input swap option not taken from memory");

    c_result_fault: cover property (valid_q && fault_q);
    c_result_clean: cover property (valid_q && !fault_q);
    c_clamp_high:   cover property (clampSel_q == CLAMP_HIGH);
    c_clamp_low:    cover property (clampSel_q == CLAMP_LOW);

endmodule // temp_comp_fine_trim_alu

// ---- tb/cal_word_model.sv ----
// Calibration memory image that programs the trim block word by word
`timescale 1ns/1ps
module cal_word_model (
    // Clock
    input  wire logic             core_clk,
    // Word writes toward the block
    output trim_alu_pkg::mem_wr_t memWr
);
    import trim_alu_pkg::*;
    logic [3:0] nib [64];
    initial begin
        memWr = '0;
        foreach (nib[i]) nib[i] = 4'h0;
    end
    // Multi-word values go low nibble first
    task automatic put(input int a, input logic [11:0] v, input int n);
        for (int i = 0; i < n; i++) nib[a+i] = v[4*i+:4];
    endtask
    // Bad parity only on word 63, which carries no field
    task automatic stream(input logic bad);
        for (int i = 0; i < 64; i++) begin
            @(negedge core_clk);
            memWr = '{1'b1, i[5:0], {(~^nib[i]) ^ (bad && i == 63), nib[i]}};
        end
        @(negedge core_clk);
        memWr = '0;
    endtask
endmodule // cal_word_model

// ---- tb/temp_comp_fine_trim_alu_tb_top.sv ----
// Self-checking bench of the temperature compensation trim ALU
`timescale 1ns/1ps
module temp_comp_fine_trim_alu_tb_top;
    import trim_alu_pkg::*;
    logic        core_clk = 1'b0;
    logic        srst = 1'b1;
    mem_wr_t     memWr;
    logic [5:0]  memRdAddr = '0;
    temp_in_t    tempIn = '0;
    logic        filterAboveHigh = 1'b0;
    logic        filterBelowLow = 1'b0;
    logic [4:0]  memRdData;
    logic [9:0]  gainDacCode, offsetDacCode;
    logic [6:0]  coarseOffsetCode, cs;
    logic [2:0]  lowClampCode, highClampCode;
    logic        inputSwapOption, resultValid, faultOut, gainRangeErr;
    logic        offsetRangeErr, parityFault, formatFault;
    clamp_sel_t  clampSel;
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          base [6] = '{12, 8, 4, 28, 24, 20};
    logic [31:0] rs = 32'h0000F62B;
    logic [31:0] r;
    logic [11:0] cf [6];
    logic [10:0] rf, ge, oe;
    logic [5:0]  cl;

    always #2.5 core_clk = ~core_clk;

    temp_comp_fine_trim_alu dut (.core_clk, .srst, .memWr, .memRdAddr, .memRdData, .tempIn,
        .filterAboveHigh, .filterBelowLow, .gainDacCode, .offsetDacCode, .coarseOffsetCode,
        .lowClampCode, .highClampCode, .inputSwapOption, .clampSel, .resultValid, .faultOut,
        .gainRangeErr, .offsetRangeErr, .parityFault, .formatFault);
    cal_word_model cal (.core_clk, .memWr);

    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction

    // Code in bits [9:0], range error in bit 10; saturates like the DAC path
    function automatic logic [10:0] poly(input logic [11:0] c0, c1, c2, input logic [9:0] t);
        logic signed [31:0] d, d2, s;
        d = $signed({21'h0, t, 1'b0}) - $signed({21'h0, rf});
        d2 = (d * d) >>> 11;
        s = $signed({20'h0, c0[9:0], 2'h0}) + (($signed(c1) * d) >>> 9)
            + (($signed(c2) * d2) >>> 9);
        return s < 0 ? 11'h400 : s > 32'sh0FFF ? 11'h7FF : {1'b0, s[11:2]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Holding valid for three cycles must still give a single result
    task automatic temp(input logic [9:0] t, input int hold);
        ge = poly(cf[0], cf[1], cf[2], t);
        oe = poly(cf[3], cf[4], cf[5], t);
        tempIn = {1'b1, t};
        repeat (hold) @(negedge core_clk);
        tempIn.valid = 1'b0;
        repeat (3 - hold) @(negedge core_clk);
        chk(resultValid, 1);
        chk(gainDacCode, ge[9:0]);
        chk(offsetDacCode, oe[9:0]);
        chk({gainRangeErr, offsetRangeErr}, {ge[10], oe[10]});
        chk(faultOut, ge[10] | oe[10]);
        @(negedge core_clk);
        chk(resultValid, 0);
    endtask

    initial begin
        repeat (20) @(negedge core_clk);
        srst = 1'b0;
        @(negedge core_clk);
        chk(memRdData, 5'h10);
        for (int img = 0; img < 3; img++) begin
            r = rnd();
            // Even reference in the second image lets a sample land on zero delta
            rf = {r[10:1], r[0] & (img != 1)};
            cs = r[17:11];
            cl = r[23:18];
            // First image has flat slopes so the in-range path is reached
            for (int k = 0; k < 6; k++) begin
                r = rnd();
                cf[k] = (k % 3 == 0) ? {2'h0, r[9:0]} : (img == 0) ? 12'h000 : r[11:0];
                cal.put(base[k], cf[k], 3);
            end
            cal.put(0, {1'b0, rf}, 3);
            cal.put(7, {11'h000, img[0]}, 1);
            cal.put(11, {8'h0, cs[3:0]}, 1);
            cal.put(15, {9'h0, cs[6:4]}, 1);
            cal.put(19, {8'h0, cl[3:0]}, 1);
            cal.put(23, {10'h0, cl[5:4]}, 1);
            cal.stream(1'b0);
            repeat (3) @(negedge core_clk);
            chk(coarseOffsetCode, cs);
            chk({highClampCode, lowClampCode}, cl);
            chk(inputSwapOption, img[0]);
            chk({parityFault, formatFault}, 0);
            for (int a = 0; a < 64; a += 9) begin
                memRdAddr = a[5:0];
                repeat (2) @(negedge core_clk);
                chk(memRdData, {~^cal.nib[a], cal.nib[a]});
            end
            for (int k = 0; k < 6; k++) begin
                r = rnd();
                // Half the reference: zero delta when the reference is even
                if (k == 2) r[9:0] = rf[10:1];
                temp(k == 0 ? 10'h000 : k == 1 ? 10'h3FF : r[9:0], k % 2 ? 3 : 1);
            end
        end
        cal.put(2, 12'h008, 1);
        cal.stream(1'b1);
        repeat (3) @(negedge core_clk);
        chk({parityFault, formatFault}, 2'h3);
        for (int c = 0; c < 4; c++) begin
            {filterAboveHigh, filterBelowLow} = c[1:0];
            repeat (8) @(negedge core_clk);
            chk(clampSel, c[1] ? CLAMP_HIGH : c[0] ? CLAMP_LOW : CLAMP_PASS);
        end
        give_verdict();
    end

    initial begin
        repeat (5000) @(posedge core_clk);
        n_mismatch++;
        give_verdict();
    end
endmodule // temp_comp_fine_trim_alu_tb_top
